/* hw/conveyor_gate_laser_control.sv */
// gate, laser on/off and system increment logic with an apb register file
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module conveyor_gate_laser_control
   import gate_laser_pkg::*;
#(
   parameter int CNT_W = 24
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // field pins, asynchronous
   input wire logic trig_pin,
   input wire logic obj_in_scan,
   input wire logic enc_pulse,
   // outputs
   output logic meas_gate,
   output logic laser_on,
   output logic sysinc_pulse,
   output logic can_send,
   output logic [CNT_W-1:0] sysinc_count
);
   initial begin
      if (CNT_W < 8 || CNT_W > 32) begin
         $error("CNT_W must be 8..32");
      end
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0] trig_s;
      logic [2:0] obj_s;
      logic [2:0] enc_s;
      logic [31:0] ctrl;
      logic [CNT_W-1:0] delay;
      logic [CNT_W-1:0] expand;
      logic [CNT_W-1:0] loff;
      logic [CNT_W-1:0] ltmo;
      logic [CNT_W-1:0] incdiv;
      logic [CNT_W-1:0] outdiv;
      logic [CNT_W-1:0] vconst;
      logic sw_trig;
      gate_state_t gst;
      logic [CNT_W-1:0] gcnt;
      logic [CNT_W-1:0] lcnt;
      logic lcount;
      logic [CNT_W-1:0] tcnt;
      logic [7:0] tick_div;
      logic [CNT_W-1:0] idiv;
      logic [CNT_W-1:0] odiv;
      logic [CNT_W-1:0] sysinc;
      logic [CNT_W-1:0] vwin;
      logic [CNT_W-1:0] vacc;
      logic [CNT_W-1:0] vel;
      logic [15:0] gate_count;
      logic gate;
      logic laser;
      logic inc_p;
      logic can_p;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_t;

   state_t s;
   state_t next_s;

   function automatic logic rise(input logic [2:0] v);
      return v[1] & ~v[2];
   endfunction

   function automatic logic fall(input logic [2:0] v);
      return ~v[1] & v[2];
   endfunction

   function automatic logic [CNT_W-1:0] w2c(input logic [31:0] d);
      return d[CNT_W-1:0];
   endfunction

   function automatic logic [31:0] c2w(input logic [CNT_W-1:0] c);
      return 32'(c);
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic trig_rise;
   logic trig_fall;
   logic enc_rise;
   logic tick;
   logic step;
   logic gate_trig;
   logic gate_end;
   logic laser_trig;
   logic laser_trig_fall;
   logic wr;
   logic rd;

   always_comb begin
      next_s = s;
      // first stage feeds only the second; edges look at stages 1 and 2
      next_s.trig_s = {s.trig_s[1:0], trig_pin};
      next_s.obj_s = {s.obj_s[1:0], obj_in_scan};
      next_s.enc_s = {s.enc_s[1:0], enc_pulse};
      trig_rise = rise(s.trig_s);
      trig_fall = fall(s.trig_s);
      enc_rise = rise(s.enc_s);
      next_s.sw_trig = 1'b0;
      next_s.inc_p = 1'b0;
      next_s.can_p = 1'b0;

      // time base: one tick per microsecond
      tick = 1'b0;
      if (s.tick_div == 8'(TICK_CYCLES - 1)) begin
         next_s.tick_div = 8'h00;
         tick = 1'b1;
      end else begin
         next_s.tick_div = s.tick_div + 8'h01;
      end
      step = s.ctrl[CTRL_TIME_MODE] ? tick : enc_rise;

      // gate source: digital input or software message
      gate_trig = s.ctrl[CTRL_GATE_SRC] ? s.sw_trig : trig_rise;

      // ---------------------------------------------------------------
      // gate
      // ---------------------------------------------------------------
      // the opening edge is pulled forward by the expansion (no lookahead
      // is possible, so it shortens the delay) and the close is pushed out
      gate_end = 1'b0;
      if (!s.ctrl[CTRL_TRIGGERED]) begin
         next_s.gst = G_IDLE;
         next_s.gate = s.obj_s[1];
         if (rise(s.obj_s)) begin
            next_s.gate_count = s.gate_count + 16'h0001;
         end
      end else begin
         unique case (s.gst)
            G_IDLE: begin
               next_s.gate = 1'b0;
               if (gate_trig) begin
                  next_s.gst = G_DELAY;
                  next_s.gcnt = '0;
               end
            end
            G_DELAY: begin
               if (s.gcnt + s.expand >= s.delay) begin
                  next_s.gst = G_OPEN;
                  next_s.gate = 1'b1;
                  next_s.gate_count = s.gate_count + 16'h0001;
               end else if (step) begin
                  next_s.gcnt = s.gcnt + 1'b1;
               end
            end
            G_OPEN: begin
               // extra objects inside the gate are ignored
               if (trig_fall && !s.ctrl[CTRL_GATE_SRC]) begin
                  next_s.gst = G_HOLD;
                  next_s.gcnt = '0;
               end else if (s.ctrl[CTRL_GATE_SRC] && gate_trig) begin
                  next_s.gst = G_HOLD;
                  next_s.gcnt = '0;
               end
            end
            G_HOLD: begin
               if (s.gcnt >= s.expand) begin
                  next_s.gst = G_IDLE;
                  next_s.gate = 1'b0;
                  gate_end = 1'b1;
               end else if (step) begin
                  next_s.gcnt = s.gcnt + 1'b1;
               end
            end
         endcase
      end

      // ---------------------------------------------------------------
      // laser
      // ---------------------------------------------------------------
      laser_trig = s.ctrl[CTRL_LASER_SRC] ? s.sw_trig : trig_rise;
      laser_trig_fall = s.ctrl[CTRL_LASER_SRC] ? 1'b0 : trig_fall;
      if (!s.ctrl[CTRL_LASER_EN]) begin
         next_s.laser = 1'b1;
         next_s.lcount = 1'b0;
      end else if (!s.ctrl[CTRL_LASER_SRCMODE]) begin
         next_s.laser = next_s.gate | (s.gst != G_IDLE);
         next_s.lcount = 1'b0;
      end else begin
         if (laser_trig) begin
            next_s.laser = 1'b1;
            next_s.lcount = 1'b0;
            next_s.lcnt = '0;
            next_s.tcnt = '0;
         end else if (laser_trig_fall || (s.ctrl[CTRL_LASER_SRC] && s.laser && !s.lcount)) begin
            next_s.lcount = 1'b1;
            next_s.lcnt = '0;
         end else if (s.lcount) begin
            if (s.lcnt >= s.loff) begin
               next_s.laser = 1'b0;
               next_s.lcount = 1'b0;
            end else if (enc_rise) begin
               next_s.lcnt = s.lcnt + 1'b1;
            end
         end else if (!s.ctrl[CTRL_LASER_SRC] && !s.trig_s[1]) begin
            // mode entry can leave the laser on with nothing on the belt
            next_s.laser = 1'b0;
         end
         // stopped conveyor: timeout from the trigger in microseconds
         if (s.ctrl[CTRL_TMO_EN] && s.laser && !laser_trig) begin
            if (s.tcnt >= s.ltmo) begin
               next_s.laser = 1'b0;
               next_s.lcount = 1'b0;
            end else if (tick) begin
               next_s.tcnt = s.tcnt + 1'b1;
            end
         end
      end

      // ---------------------------------------------------------------
      // system increment and velocity
      // ---------------------------------------------------------------
      if (enc_rise) begin
         if (s.idiv + 1'b1 >= s.incdiv) begin
            next_s.idiv = '0;
            next_s.sysinc = s.sysinc + 1'b1;
            next_s.inc_p = 1'b1;
            if (s.odiv + 1'b1 >= s.outdiv) begin
               next_s.odiv = '0;
               next_s.can_p = 1'b1;
            end else begin
               next_s.odiv = s.odiv + 1'b1;
            end
         end else begin
            next_s.idiv = s.idiv + 1'b1;
         end
      end
      // encoder pulses per millisecond, or the constant
      if (s.ctrl[CTRL_VEL_CONST]) begin
         next_s.vel = s.vconst;
      end else begin
         if (enc_rise) begin
            next_s.vacc = s.vacc + 1'b1;
         end
         if (tick) begin
            if (s.vwin >= CNT_W'(VEL_WINDOW_TICKS - 1)) begin
               next_s.vwin = '0;
               next_s.vel = s.vacc;
               next_s.vacc = '0;
            end else begin
               next_s.vwin = s.vwin + 1'b1;
            end
         end
      end

      // ---------------------------------------------------------------
      // apb slave, zero wait states
      // ---------------------------------------------------------------
      wr = psel && penable && pwrite;
      rd = psel && !penable && !pwrite;
      next_s.pready = psel && !penable;
      next_s.pslverr = 1'b0;
      if (wr) begin
         unique case (paddr)
            ADDR_CTRL: next_s.ctrl = pwdata;
            ADDR_DELAY: next_s.delay = w2c(pwdata);
            ADDR_EXPAND: next_s.expand = w2c(pwdata);
            ADDR_LOFF: next_s.loff = w2c(pwdata);
            ADDR_LTMO: next_s.ltmo = w2c(pwdata);
            ADDR_INCDIV: next_s.incdiv = w2c(pwdata);
            ADDR_OUTDIV: next_s.outdiv = w2c(pwdata);
            ADDR_VCONST: next_s.vconst = w2c(pwdata);
            ADDR_SWTRIG: next_s.sw_trig = pwdata[0];
            default: ;
         endcase
      end
      if (psel && !penable) begin
         next_s.pslverr = (paddr > ADDR_VEL) || (paddr[1:0] != 2'b00);
      end
      if (rd) begin
         unique case (paddr)
            ADDR_CTRL: next_s.prdata = s.ctrl;
            ADDR_DELAY: next_s.prdata = c2w(s.delay);
            ADDR_EXPAND: next_s.prdata = c2w(s.expand);
            ADDR_LOFF: next_s.prdata = c2w(s.loff);
            ADDR_LTMO: next_s.prdata = c2w(s.ltmo);
            ADDR_INCDIV: next_s.prdata = c2w(s.incdiv);
            ADDR_OUTDIV: next_s.prdata = c2w(s.outdiv);
            ADDR_VCONST: next_s.prdata = c2w(s.vconst);
            ADDR_STATUS: next_s.prdata = {s.gate_count, 9'h000, s.obj_s[1], s.trig_s[1],
                                          s.lcount, s.gst, s.laser, s.gate};
            ADDR_SYSINC: next_s.prdata = c2w(s.sysinc);
            ADDR_VEL: next_s.prdata = c2w(s.vel);
            default: next_s.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.incdiv <= CNT_W'(DIV_RESET);
         s.outdiv <= CNT_W'(DIV_RESET);
         s.ctrl <= CTRL_RESET;
         s.laser <= 1'b1;
         s.gst <= G_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign meas_gate = s.gate;
   assign laser_on = s.laser;
   assign sysinc_pulse = s.inc_p;
   assign can_send = s.can_p;
   assign sysinc_count = s.sysinc;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence trig_edge_s;
      !s.trig_s[2] && s.trig_s[1];
   endsequence

   free_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !s.ctrl[CTRL_TRIGGERED] && $past(!s.ctrl[CTRL_TRIGGERED]) |-> s.gate == $past(s.obj_s[1]))
      else $error("free gate does not follow object");
   laser_cont_a: assert property (@(posedge pclk) disable iff (!presetn)
      !s.ctrl[CTRL_LASER_EN] |=> s.laser)
      else $error("laser off while control disabled");
   laser_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s.ctrl[CTRL_LASER_EN] && s.ctrl[CTRL_LASER_SRCMODE] && !s.ctrl[CTRL_LASER_SRC]) and trig_edge_s
      |=> s.laser && !s.lcount && s.lcnt == '0)
      else $error("trigger did not switch laser on");
   laser_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.ctrl[CTRL_LASER_EN] && s.ctrl[CTRL_LASER_SRCMODE] && s.lcount && s.lcnt >= s.loff
      && !laser_trig |=> !s.laser)
      else $error("laser not off at off distance");
   count_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.ctrl[CTRL_LASER_EN] && s.ctrl[CTRL_LASER_SRCMODE] && !s.ctrl[CTRL_LASER_SRC]
      && trig_fall && !s.ctrl[CTRL_TMO_EN] |=> s.lcount && s.lcnt == '0)
      else $error("rear edge did not start count");
   gate_open_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.gst == G_DELAY && s.ctrl[CTRL_TRIGGERED] && s.gcnt + s.expand < s.delay |=> !s.gate)
      else $error("gate opened before delay");
   one_meas_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.ctrl[CTRL_TRIGGERED] && $past(s.ctrl[CTRL_TRIGGERED]) && s.gst == G_OPEN && $past(s.gst) == G_OPEN
      |-> $stable(s.gate_count))
      else $error("extra measurement inside gate");
   inc_div_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.inc_p |-> s.sysinc == $past(s.sysinc) + 1'b1 && $past(enc_rise))
      else $error("system increment without divided pulse");
   can_pace_a: assert property (@(posedge pclk) disable iff (!presetn)
      s.can_p |-> s.inc_p)
      else $error("can send off an increment");
   sync_a: assert property (@(posedge pclk) disable iff (!presetn)
      enc_rise |-> $past(s.enc_s[0]) && !$past(s.enc_s[1]))
      else $error("encoder edge not synchronised");
endmodule

/* hw/gate_laser_pkg.sv */
// shared constants, register map and carrier types for the gate and laser controller
package gate_laser_pkg;
   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_DELAY = 12'h004;
   localparam logic [11:0] ADDR_EXPAND = 12'h008;
   localparam logic [11:0] ADDR_LOFF = 12'h00c;
   localparam logic [11:0] ADDR_LTMO = 12'h010;
   localparam logic [11:0] ADDR_INCDIV = 12'h014;
   localparam logic [11:0] ADDR_OUTDIV = 12'h018;
   localparam logic [11:0] ADDR_VCONST = 12'h01c;
   localparam logic [11:0] ADDR_SWTRIG = 12'h020;
   localparam logic [11:0] ADDR_STATUS = 12'h024;
   localparam logic [11:0] ADDR_SYSINC = 12'h028;
   localparam logic [11:0] ADDR_VEL = 12'h02c;
   // ---------------------------------------------------------------
   // control field positions
   // ---------------------------------------------------------------
   localparam int CTRL_TRIGGERED = 0;
   localparam int CTRL_GATE_SRC = 1;
   localparam int CTRL_TIME_MODE = 2;
   localparam int CTRL_LASER_EN = 3;
   localparam int CTRL_LASER_SRCMODE = 4;
   localparam int CTRL_LASER_SRC = 5;
   localparam int CTRL_TMO_EN = 6;
   localparam int CTRL_VEL_CONST = 7;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] DIV_RESET = 32'h0000_0001;
   // ---------------------------------------------------------------
   // timing: 200 MHz clock, time-mode tick of 1 us
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int TICK_US = 1;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int VEL_WINDOW_US = 1000;
   localparam int VEL_WINDOW_TICKS = VEL_WINDOW_US / TICK_US;

   typedef enum logic [1:0] {G_IDLE, G_DELAY, G_OPEN, G_HOLD} gate_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
endpackage

/* sim/conveyor_model.sv */
// behavioural conveyor: photoelectric switch, object in scan line and encoder
`timescale 1ns/1ps
module conveyor_model (
   // clock
   input wire logic pclk,
   // field pins
   output logic trig_pin,
   output logic obj_in_scan,
   output logic enc_pulse
);
   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   initial begin
      trig_pin = 1'b0;
      obj_in_scan = 1'b0;
      enc_pulse = 1'b0;
   end
   // pins move just after an edge; callers leave a gap between objects
   task automatic set_trig(input logic v);
      @(posedge pclk);
      trig_pin <= v;
   endtask
   task automatic set_obj(input logic v);
      @(posedge pclk);
      obj_in_scan <= v;
   endtask
   // 4 cycles high, 4 low: the input sampler needs 3 each way
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge pclk);
         enc_pulse <= 1'b1;
         repeat (4) @(posedge pclk);
         enc_pulse <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask
endmodule

/* sim/test_conveyor_gate_laser_control.sv */
// self-checking bench for the gate and laser controller
`timescale 1ns/1ps
module test_conveyor_gate_laser_control import gate_laser_pkg::*;;
   // ---------------------------------------------------------------
   // signals and instances
   // ---------------------------------------------------------------
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_t;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic trig_pin;
   logic obj_in_scan;
   logic enc_pulse;
   logic meas_gate;
   logic laser_on;
   logic sysinc_pulse;
   logic can_send;
   logic [23:0] sysinc_count;
   logic [23:0] s0;
   int n_mismatch = 0;
   int check_count = 0;
   int n_inc, n_can;
   row_t rows [8] = '{
      '{1'b0, ADDR_CTRL, 32'h0, CTRL_RESET, 1'b0},
      '{1'b0, ADDR_INCDIV, 32'h0, DIV_RESET, 1'b0},
      '{1'b0, ADDR_OUTDIV, 32'h0, DIV_RESET, 1'b0},
      '{1'b1, ADDR_DELAY, 32'hff00_1234, 32'h0000_1234, 1'b0},
      '{1'b1, ADDR_VCONST, 32'h0000_0abc, 32'h0000_0abc, 1'b0},
      '{1'b1, ADDR_SYSINC, 32'h0000_0055, 32'h0000_0000, 1'b0},
      '{1'b1, 12'h030, 32'h0000_0007, 32'h0000_0000, 1'b1},
      '{1'b1, 12'h006, 32'h0000_0007, 32'h0000_0000, 1'b1}};

   conveyor_gate_laser_control conveyor_gate_laser_control_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_pin(trig_pin),
      .obj_in_scan(obj_in_scan), .enc_pulse(enc_pulse), .meas_gate(meas_gate), .laser_on(laser_on),
      .sysinc_pulse(sysinc_pulse), .can_send(can_send), .sysinc_count(sysinc_count));
   conveyor_model conveyor_model_inst (.pclk(pclk), .trig_pin(trig_pin), .obj_in_scan(obj_in_scan),
      .enc_pulse(enc_pulse));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (sysinc_pulse === 1'b1) n_inc++;
      if (can_send === 1'b1) n_can++;
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic chk1(input string nm, input logic exp, input logic got);
      chk(nm, {31'h0, exp}, {31'h0, got});
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 50) chk1("pready", 1'b1, 1'b0);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r);
      chk1(nm, xe, e);
   endtask
   task automatic print_verdict();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // a hang costs a mismatch; the whole run needs well under 10k cycles
   initial begin
      repeat (50000) @(posedge pclk);
      n_mismatch++;
      print_verdict();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      settle(3);
      chk1("laser_rst", 1'b1, laser_on);
      chk1("gate_rst", 1'b0, meas_gate);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rdc("row", rows[i].a, rows[i].exp, rows[i].err);
      end
      conveyor_model_inst.set_obj(1'b1);
      settle(8);
      chk1("gate_free_on", 1'b1, meas_gate);
      chk1("laser_always", 1'b1, laser_on);
      conveyor_model_inst.set_obj(1'b0);
      settle(8);
      chk1("gate_free_off", 1'b0, meas_gate);
      // track gate, expansion 0 then 2, laser following the gate
      wr(ADDR_DELAY, 32'h4);
      wr(ADDR_CTRL, (32'h1 << CTRL_TRIGGERED) | (32'h1 << CTRL_LASER_EN));
      for (int e = 0; e <= 2; e += 2) begin
         wr(ADDR_EXPAND, 32'(e));
         conveyor_model_inst.set_trig(1'b1);
         settle(8);
         chk1("laser_gate", 1'b1, laser_on);
         conveyor_model_inst.pulses(3 - e);
         settle(8);
         chk1("gate_wait", 1'b0, meas_gate);
         conveyor_model_inst.pulses(1);
         settle(8);
         chk1("gate_open", 1'b1, meas_gate);
         conveyor_model_inst.set_obj(1'b1);
         conveyor_model_inst.set_obj(1'b0);
         settle(8);
         chk1("gate_one", 1'b1, meas_gate);
         conveyor_model_inst.set_trig(1'b0);
         settle(8);
         chk1("gate_tail", e != 0, meas_gate);
         conveyor_model_inst.pulses(e);
         settle(8);
         chk1("gate_shut", 1'b0, meas_gate);
         chk1("laser_idle", 1'b0, laser_on);
      end
      // software trigger, delay in microseconds
      wr(ADDR_DELAY, 32'h2);
      wr(ADDR_EXPAND, 32'h0);
      wr(ADDR_CTRL, (32'h1 << CTRL_TRIGGERED) | (32'h1 << CTRL_GATE_SRC) | (32'h1 << CTRL_TIME_MODE));
      wr(ADDR_SWTRIG, 32'h1);
      settle(100);
      chk1("gate_time_wait", 1'b0, meas_gate);
      settle(500);
      chk1("gate_time_open", 1'b1, meas_gate);
      wr(ADDR_SWTRIG, 32'h1);
      settle(8);
      chk1("gate_sw_shut", 1'b0, meas_gate);
      // laser from its own source with an off distance of 4
      wr(ADDR_LOFF, 32'h4);
      wr(ADDR_CTRL, (32'h1 << CTRL_LASER_EN) | (32'h1 << CTRL_LASER_SRCMODE));
      settle(4);
      chk1("laser_off_idle", 1'b0, laser_on);
      conveyor_model_inst.set_trig(1'b1);
      settle(6);
      chk1("laser_trig", 1'b1, laser_on);
      conveyor_model_inst.set_trig(1'b0);
      conveyor_model_inst.pulses(3);
      settle(8);
      chk1("laser_count", 1'b1, laser_on);
      conveyor_model_inst.set_trig(1'b1);
      settle(4);
      conveyor_model_inst.set_trig(1'b0);
      conveyor_model_inst.pulses(3);
      settle(8);
      chk1("laser_restart", 1'b1, laser_on);
      conveyor_model_inst.pulses(1);
      settle(8);
      chk1("laser_dist_off", 1'b0, laser_on);
      // slave setup: laser from the software trigger, count starts at once
      wr(ADDR_CTRL, (32'h1 << CTRL_LASER_EN) | (32'h1 << CTRL_LASER_SRCMODE) | (32'h1 << CTRL_LASER_SRC));
      wr(ADDR_SWTRIG, 32'h1);
      settle(4);
      chk1("laser_sw_on", 1'b1, laser_on);
      conveyor_model_inst.pulses(4);
      settle(8);
      chk1("laser_sw_off", 1'b0, laser_on);
      // stalled conveyor: timeout of 2 us
      wr(ADDR_LTMO, 32'h2);
      wr(ADDR_CTRL, (32'h1 << CTRL_LASER_EN) | (32'h1 << CTRL_LASER_SRCMODE) | (32'h1 << CTRL_TMO_EN));
      conveyor_model_inst.set_trig(1'b1);
      settle(4);
      conveyor_model_inst.set_trig(1'b0);
      settle(150);
      chk1("laser_tmo_on", 1'b1, laser_on);
      settle(650);
      chk1("laser_tmo_off", 1'b0, laser_on);
      // system increment: 12 pulses / 3 = 4 increments, / 2 = 2 sends
      wr(ADDR_CTRL, 32'h1 << CTRL_VEL_CONST);
      wr(ADDR_INCDIV, 32'h3);
      wr(ADDR_OUTDIV, 32'h2);
      s0 = sysinc_count;
      n_inc = 0;
      n_can = 0;
      conveyor_model_inst.pulses(12);
      settle(8);
      chk("sysinc_pulses", 32'h4, 32'(n_inc));
      chk("can_sends", 32'h2, 32'(n_can));
      chk("sysinc_count", {8'h0, s0 + 24'h4}, {8'h0, sysinc_count});
      rdc("sysinc_reg", ADDR_SYSINC, {8'h0, s0 + 24'h4}, 1'b0);
      rdc("vel_const", ADDR_VEL, 32'h0000_0abc, 1'b0);
      print_verdict();
   end
endmodule
